// [ssr_shifter.sv]
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module ssr_fifo #(
	parameter int unsigned W     = 8,
	parameter int unsigned DEPTH = 4
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	// control
	input  wire logic         clr_i,
	input  wire logic         push_i,
	input  wire logic [W-1:0] wdata_i,
	input  wire logic         pop_i,
	// state
	output logic      [W-1:0] rdata_o,
	output logic      [7:0]   count_o,
	output logic              full_o,
	output logic              empty_o
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

	logic [W-1:0]  mem_q [DEPTH];
	logic [W-1:0]  mem_d [DEPTH];
	logic [PW-1:0] rptr_q, rptr_d, wptr_q, wptr_d, wp;
	logic [CW-1:0] cnt_q, cnt_d, cn;

	function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
		return (p == PTR_LAST) ? '0 : PW'(p + 1'b1);
	endfunction

	assign rdata_o = mem_q[rptr_q];
	assign count_o = 8'(cnt_q);
	assign full_o  = (cnt_q == CW'(DEPTH));
	assign empty_o = (cnt_q == '0);

	always_comb begin
		mem_d  = mem_q;
		rptr_d = rptr_q;
		wp     = wptr_q;
		cn     = cnt_q;
		if (clr_i) begin
			rptr_d = '0;
			wp     = '0;
			cn     = '0;
		end else if (pop_i && !empty_o) begin
			rptr_d = nxt(rptr_q);
			cn     = CW'(cn - 1'b1);
		end
		wptr_d = wp;
		cnt_d  = cn;
		if (push_i && (clr_i || !full_o)) begin
			mem_d[wp] = wdata_i;
			wptr_d    = nxt(wp);
			cnt_d     = CW'(cn + 1'b1);
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rptr_q <= '0;
			wptr_q <= '0;
			cnt_q  <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else begin
			rptr_q <= rptr_d;
			wptr_q <= wptr_d;
			cnt_q  <= cnt_d;
			mem_q  <= mem_d;
		end
	end
endmodule

module ssr_shifter
	import ssr_pkg::*;
#(
	parameter int unsigned LENGTH          = LEN_DEF,
	parameter bit          SHIFT_LEFT      = 1'b0,
	parameter bit          USE_LOAD        = 1'b1,
	parameter bit          USE_STORE       = 1'b1,
	parameter bit          USE_SHIFT_IN    = 1'b1,
	parameter bit          USE_SHIFT_OUT   = 1'b1,
	parameter bit          DEFAULT_SHIFT   = 1'b0,
	parameter bit          USE_INT         = 1'b1,
	parameter bit          RESET_CONNECTED = 1'b1,
	parameter int unsigned FIFO_DEPTH      = FIFO_DEPTH_DEF
) (
	// clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              rstn_i,
	// apb slave
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [DATA_W-1:0] pwdata_i,
	output logic      [DATA_W-1:0] prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// design-side pins
	input  wire logic              shift_in_i,
	input  wire logic              load_i,
	input  wire logic              store_i,
	input  wire logic              srst_i,
	output logic                   shift_out_o,
	output logic                   irq_o
);
	if (LENGTH < LEN_MIN || LENGTH > LEN_MAX) begin : g_len_check
		$error("ssr_shifter: LENGTH out of range");
	end

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return a == OFF_CTRL || a == OFF_INT_MASK || a == OFF_INT_STAT
			|| a == OFF_REG_VALUE || a == OFF_CAPTURE || a == OFF_FIFO_STAT
			|| a == OFF_IN_DATA || a == OFF_OUT_DATA;
	endfunction

	logic [LENGTH-1:0] sr_q, sr_d;
	logic              load_prev_q, load_prev_d, store_prev_q, store_prev_d;
	logic              load_pend_q, load_pend_d, store_pend_q, store_pend_d;
	logic              en_q, en_d;
	logic [2:0]        mask_q, mask_d;
	ssr_ev_type        stat_q, stat_d, ev, rd_clr;
	logic              pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
	logic [DATA_W-1:0] prdata_q, prdata_d;

	logic              acc, done, wr, rd, rst_eff, sin, load_go, store_go, capture;
	logic              in_push, in_full, in_empty, out_pop, out_full, out_empty;
	logic [LENGTH-1:0] in_rdata, out_rdata;
	logic [7:0]        in_cnt, out_cnt;

	assign acc  = psel_i & penable_i;
	assign done = acc & pready_q;
	assign wr   = done & pwrite_i;
	assign rd   = done & ~pwrite_i;

	assign rst_eff  = RESET_CONNECTED ? srst_i : 1'b0;
	assign sin      = USE_SHIFT_IN ? shift_in_i : DEFAULT_SHIFT;
	assign load_go  = load_pend_q & ~in_empty & ~rst_eff;
	assign store_go = store_pend_q;
	assign capture  = wr && paddr_i == OFF_CAPTURE;
	assign in_push  = wr && paddr_i == OFF_IN_DATA;
	assign out_pop  = rd && paddr_i == OFF_OUT_DATA;

	ssr_fifo #(.W(LENGTH), .DEPTH(FIFO_DEPTH)) u_in_fifo (
		.clk_i   (sys_clk_i),
		.rstn_i  (rstn_i),
		.clr_i   (1'b0),
		.push_i  (in_push),
		.wdata_i (pwdata_i[LENGTH-1:0]),
		.pop_i   (load_go),
		.rdata_o (in_rdata),
		.count_o (in_cnt),
		.full_o  (in_full),
		.empty_o (in_empty)
	);

	// capture flushes older words so the pop returns the fresh value
	ssr_fifo #(.W(LENGTH), .DEPTH(FIFO_DEPTH)) u_out_fifo (
		.clk_i   (sys_clk_i),
		.rstn_i  (rstn_i),
		.clr_i   (capture),
		.push_i  (store_go | capture),
		.wdata_i (sr_q),
		.pop_i   (out_pop),
		.rdata_o (out_rdata),
		.count_o (out_cnt),
		.full_o  (out_full),
		.empty_o (out_empty)
	);

	// shift path and transfers
	always_comb begin
		load_prev_d  = load_i;
		store_prev_d = store_i;
		load_pend_d  = load_pend_q;
		store_pend_d = 1'b0;
		if (USE_LOAD && load_i && !load_prev_q) begin
			load_pend_d = 1'b1;
		end else if (load_pend_q) begin
			load_pend_d = 1'b0;
		end
		if (USE_STORE && store_i && !store_prev_q) begin
			store_pend_d = 1'b1;
		end
		if (rst_eff) begin
			sr_d = '0;
		end else if (wr && paddr_i == OFF_REG_VALUE) begin
			sr_d = pwdata_i[LENGTH-1:0];
		end else if (load_go) begin
			sr_d = in_rdata;
		end else if (en_q) begin
			if (SHIFT_LEFT) begin
				sr_d = {sr_q[LENGTH-2:0], sin};
			end else begin
				sr_d = {sin, sr_q[LENGTH-1:1]};
			end
		end else begin
			sr_d = sr_q;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sr_q         <= '0;
			load_prev_q  <= 1'b0;
			store_prev_q <= 1'b0;
			load_pend_q  <= 1'b0;
			store_pend_q <= 1'b0;
		end else begin
			sr_q         <= sr_d;
			load_prev_q  <= load_prev_d;
			store_prev_q <= store_prev_d;
			load_pend_q  <= load_pend_d;
			store_pend_q <= store_pend_d;
		end
	end

	assign shift_out_o = USE_SHIFT_OUT ? (SHIFT_LEFT ? sr_q[LENGTH-1] : sr_q[0]) : 1'b0;

	// registers, status and interrupt
	always_comb begin
		ev       = EV_NONE;
		ev.load  = load_go;
		ev.store = store_go;
		ev.rst   = rst_eff;
		rd_clr   = EV_NONE;
		if (rd && paddr_i == OFF_INT_STAT) begin
			rd_clr = ssr_ev_type'(prdata_q[2:0]);
		end
		stat_d = (stat_q & ~rd_clr) | ev;
		irq_d  = USE_INT && ((stat_d & mask_q) != '0);
		en_d   = en_q;
		mask_d = mask_q;
		if (wr && paddr_i == OFF_CTRL) begin
			en_d = pwdata_i[CTRL_EN_BIT];
		end
		if (wr && paddr_i == OFF_INT_MASK && USE_INT) begin
			mask_d = pwdata_i[2:0];
		end
		pready_d  = acc & ~pready_q;
		prdata_d  = prdata_q;
		pslverr_d = 1'b0;
		if (acc && !pready_q) begin
			pslverr_d = ~is_mapped(paddr_i);
			prdata_d  = '0;
			if (!pwrite_i) begin
				unique case (paddr_i)
					OFF_CTRL: prdata_d[CTRL_EN_BIT] = en_q;
					OFF_INT_MASK: prdata_d[2:0] = mask_q;
					OFF_INT_STAT: prdata_d[2:0] = stat_q;
					OFF_REG_VALUE: prdata_d = DATA_W'(sr_q);
					OFF_FIFO_STAT: begin
						prdata_d[FST_IN_CNT_LSB +: 8]  = in_cnt;
						prdata_d[FST_OUT_CNT_LSB +: 8] = out_cnt;
						prdata_d[FST_IN_FULL]          = in_full;
						prdata_d[FST_IN_EMPTY]         = in_empty;
						prdata_d[FST_OUT_FULL]         = out_full;
						prdata_d[FST_OUT_EMPTY]        = out_empty;
					end
					OFF_OUT_DATA: prdata_d = DATA_W'(out_rdata);
					default: prdata_d = '0;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stat_q    <= EV_NONE;
			irq_q     <= 1'b0;
			en_q      <= CTRL_EN_RST;
			mask_q    <= INT_MASK_RST;
			pready_q  <= 1'b0;
			prdata_q  <= PRDATA_RST;
			pslverr_q <= 1'b0;
		end else begin
			stat_q    <= stat_d;
			irq_q     <= irq_d;
			en_q      <= en_d;
			mask_q    <= mask_d;
			pready_q  <= pready_d;
			prdata_q  <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign irq_o     = irq_q;
	assign pready_o  = pready_q;
	assign prdata_o  = prdata_q;
	assign pslverr_o = pslverr_q;
endmodule

// [ssr_pkg.sv]
package ssr_pkg;

	localparam int unsigned ADDR_W       = 8;
	localparam int unsigned DATA_W       = 32;
	localparam int unsigned LEN_DEF      = 8;
	localparam int unsigned LEN_MIN      = 2;
	localparam int unsigned LEN_MAX      = 32;
	localparam int unsigned FIFO_DEPTH_DEF = 4;

	localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_INT_MASK  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_INT_STAT  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_REG_VALUE = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_CAPTURE   = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_FIFO_STAT = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_IN_DATA   = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_OUT_DATA  = 8'h1C;

	localparam int unsigned CTRL_EN_BIT    = 0;
	localparam int unsigned FST_IN_CNT_LSB = 0;
	localparam int unsigned FST_OUT_CNT_LSB = 8;
	localparam int unsigned FST_IN_FULL    = 16;
	localparam int unsigned FST_IN_EMPTY   = 17;
	localparam int unsigned FST_OUT_FULL   = 18;
	localparam int unsigned FST_OUT_EMPTY  = 19;

	localparam logic              CTRL_EN_RST = 1'b0;
	localparam logic [2:0]        INT_MASK_RST = 3'h0;
	localparam logic [DATA_W-1:0] PRDATA_RST = 32'h0000_0000;

	typedef struct packed {
		logic rst;
		logic store;
		logic load;
	} ssr_ev_type;

	localparam ssr_ev_type EV_NONE = '{rst: 1'b0, store: 1'b0, load: 1'b0};

endpackage

// [ssr_shifter_asserts.sv]
`timescale 1ns/1ns
module ssr_chk
	import ssr_pkg::*;
#(
	parameter int unsigned LENGTH = LEN_DEF
) (
	// clock, reset, apb
	input wire logic              sys_clk_i,
	input wire logic              rstn_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic              psel_i,
	input wire logic              penable_i,
	input wire logic              pwrite_i,
	input wire logic [DATA_W-1:0] pwdata_i,
	input wire logic [DATA_W-1:0] prdata_o,
	input wire logic              pready_o,
	input wire logic              pslverr_o,
	// pins
	input wire logic              shift_in_i,
	input wire logic              load_i,
	input wire logic              store_i,
	input wire logic              srst_i,
	input wire logic              shift_out_o,
	input wire logic              irq_o
);
	logic       wr;
	logic       en_q, en_d;
	logic [2:0] msk_q, msk_d;
	logic [5:0] qc_q, qc_d;
	logic       lp_q;

	assign wr = psel_i && penable_i && pready_o && pwrite_i;
	// shadow of enable and mask, count of undisturbed shift edges
	always_comb begin
		en_d = (wr && paddr_i == OFF_CTRL) ? pwdata_i[0] : en_q;
		msk_d = (wr && paddr_i == OFF_INT_MASK) ? pwdata_i[2:0] : msk_q;
		qc_d = 6'h00;
		// a load transfer replaces the shift one edge after load was high
		if (en_q && !psel_i && !load_i && !lp_q && !srst_i)
			qc_d = qc_q + {5'h00, qc_q != 6'h3F};
	end
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			en_q <= 1'b0;
			msk_q <= 3'h0;
			qc_q <= 6'h00;
			lp_q <= 1'b0;
		end else begin
			en_q <= en_d;
			msk_q <= msk_d;
			qc_q <= qc_d;
			lp_q <= load_i;
		end
	end

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	ready_wait_a: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
		else $error("pready not after one wait state");
	ready_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("pready longer than one cycle");
	addr_err_a: assert property (pready_o && paddr_i[1:0] == 2'h0
		|-> pslverr_o == (paddr_i > OFF_OUT_DATA)) else $error("wrong pslverr");
	err_data_a: assert property (pready_o && pslverr_o && !pwrite_i |-> prdata_o == '0)
		else $error("error read data not zero");
	srst_clear_a: assert property (srst_i |=> !shift_out_o)
		else $error("shift out not cleared by reset");
	shift_right_a: assert property (qc_q > LENGTH |-> shift_out_o == $past(shift_in_i, LENGTH))
		else $error("serial out not delayed input");
	rst_irq_a: assert property (srst_i && msk_q[2] |-> ##[1:2] irq_o)
		else $error("no irq on reset");
	store_irq_a: assert property ($rose(store_i) && msk_q[1] |-> ##[1:3] irq_o)
		else $error("no irq on store");
	irq_mask_a: assert property (irq_o |-> (msk_q | $past(msk_q)) != 3'h0)
		else $error("irq with all sources masked");

	cover property (srst_i && msk_q[2]);
	cover property (qc_q > LENGTH);
	cover property ($rose(store_i) && msk_q[1]);
endmodule

bind ssr_shifter ssr_chk #(.LENGTH(LENGTH)) u_ssr_chk (.sys_clk_i, .rstn_i, .paddr_i,
	.psel_i, .penable_i, .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
	.shift_in_i, .load_i, .store_i, .srst_i, .shift_out_o, .irq_o);

// [ssr_far_model.sv]
`timescale 1ns/1ns
module ssr_far_model (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	// requests from bench
	input  wire logic       load_req_i,
	input  wire logic       store_req_i,
	input  wire logic [7:0] pat_i,
	// to the shifter
	output logic            shift_in_o,
	output logic            load_o,
	output logic            store_o
);
	logic [2:0] bit_q;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bit_q <= 3'h0;
			shift_in_o <= 1'b0;
			load_o <= 1'b0;
			store_o <= 1'b0;
		end else begin
			bit_q <= bit_q + 3'h1;
			shift_in_o <= pat_i[bit_q];
			load_o <= load_req_i && !load_o;
			store_o <= store_req_i && !store_o;
		end
	end
endmodule

// [tb_top.sv]
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("MISMATCH %s exp %0h got %0h", nm, e, g); \
	end \
end
module tb_top;
	import ssr_pkg::*;
	localparam int unsigned LEN = 4;
	logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, pready, pslverr, sin, load, store, srst = 1'b0;
	logic        sout, irq, lreq = 1'b0, sreq = 1'b0;
	logic [7:0]  paddr = 8'h00, pat = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	int          n_errors = 0, samples_checked = 0;

	always #20 clk = ~clk;

	ssr_shifter #(.LENGTH(LEN)) u_ssr_shifter (.sys_clk_i(clk), .rstn_i(rstn),
		.paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.shift_in_i(sin), .load_i(load), .store_i(store), .srst_i(srst),
		.shift_out_o(sout), .irq_o(irq));
	ssr_far_model u_ssr_far_model (.clk_i(clk), .rstn_i(rstn), .load_req_i(lreq),
		.store_req_i(sreq), .pat_i(pat), .shift_in_o(sin), .load_o(load), .store_o(store));

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// the wait ends once pready is seen high; only the watchdog bounds it
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string nm);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		`CHK(nm, x, r)
	endtask
	task automatic pulse(input bit s);
		if (s)
			sreq <= 1'b1;
		else
			lreq <= 1'b1;
		@(posedge clk);
		lreq <= 1'b0;
		sreq <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic t_regs;
		logic [31:0] r;
		logic        e;
		rdc(OFF_CTRL, 32'h0, "ctrl");
		rdc(OFF_FIFO_STAT, 32'h000A_0000, "fifo_stat");
		apb(1'b0, 8'h40, 32'h0, r, e);
		`CHK("unmapped_err", 1'b1, e)
		`CHK("unmapped_data", 32'h0, r)
	endtask
	// load transfer falls due on the same edge as reset, which blocks it
	task automatic t_srst;
		wr(OFF_IN_DATA, 32'h7);
		wr(OFF_REG_VALUE, 32'hC);
		wr(OFF_INT_MASK, 32'h4);
		rdc(OFF_INT_STAT, 32'h0, "stat_idle");
		lreq <= 1'b1;
		@(posedge clk);
		lreq <= 1'b0;
		@(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK("irq_rst", 1'b1, irq)
		rdc(OFF_REG_VALUE, 32'h0, "reg_rst");
		rdc(OFF_FIFO_STAT, 32'h0008_0001, "queue_kept");
		rdc(OFF_INT_STAT, 32'h4, "stat_rst");
		rdc(OFF_INT_STAT, 32'h0, "stat_clr");
		repeat (2) @(posedge clk);
		`CHK("irq_clr", 1'b0, irq)
	endtask
	task automatic t_load;
		wr(OFF_INT_MASK, 32'h1);
		wr(OFF_IN_DATA, 32'h5);
		pulse(1'b0);
		rdc(OFF_REG_VALUE, 32'h7, "load_old");
		`CHK("irq_load", 1'b1, irq)
		pulse(1'b0);
		rdc(OFF_REG_VALUE, 32'h5, "load_next");
		pulse(1'b0);
		rdc(OFF_REG_VALUE, 32'h5, "load_empty");
		rdc(OFF_INT_STAT, 32'h1, "stat_load");
	endtask
	task automatic t_store;
		wr(OFF_INT_MASK, 32'h2);
		wr(OFF_REG_VALUE, 32'h6);
		pulse(1'b1);
		`CHK("irq_store", 1'b1, irq)
		wr(OFF_REG_VALUE, 32'h2);
		pulse(1'b1);
		rdc(OFF_OUT_DATA, 32'h6, "store_word");
		pulse(1'b1);
		wr(OFF_REG_VALUE, 32'h3);
		wr(OFF_CAPTURE, 32'h0);
		rdc(OFF_OUT_DATA, 32'h3, "capture");
		rdc(OFF_FIFO_STAT, 32'h000A_0000, "older_lost");
	endtask
	task automatic t_shift;
		wr(OFF_REG_VALUE, 32'hFFFF_FFF8);
		rdc(OFF_REG_VALUE, 32'h8, "reg_direct");
		`CHK("sout_lsb", 1'b0, sout)
		pat <= 8'hB4;
		wr(OFF_CTRL, 32'h1);
		repeat (12) @(posedge clk);
		pat <= 8'hFF;
		repeat (LEN + 4) @(posedge clk);
		rdc(OFF_REG_VALUE, 32'hF, "shifted_ones");
		// 8 lands at the write edge, then two ones enter at the top before capture
		wr(OFF_REG_VALUE, 32'h8);
		rdc(OFF_REG_VALUE, 32'hE, "shift_dir");
	endtask

	task automatic test_done;
		if (n_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_srst();
		t_load();
		t_store();
		t_shift();
		test_done();
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		test_done();
	end
endmodule
